// file: core/pwm_channel.sv
// Operation
// RL1 - After every period, the first included, the counter reloads to one, not zero.
// RL2 - The first period after start counts from zero, one tick longer than later ones.
// RL3 - Enabling a channel in center-aligned mode raises its event at once.
// RL4 - Software enables and reads status before unmasking the interrupt in center mode.
// RL5 - A zero period written through the update value is ignored.
// RL6 - Software never writes zero as the update value.
// RL7 - After a mid-period disable the enable status reads one until the period ends.
// RL8 - Software trusts the status of a disabled channel only after one full period.
// RL9 - The counter steps once per channel tick and the period ends at the period value.
module pwm_channel
    import pwm_chan_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             chan_enable,
    input  wire logic             chan_disable,
    input  wire logic             center_align_select,
    input  wire logic             polarity,
    input  wire logic [DIV_W-1:0] div_ratio,
    input  wire logic [15:0]      init_period,
    input  wire logic [15:0]      duty,
    input  wire logic             update_write,
    input  wire logic [15:0]      channel_update_value,
    input  wire logic             event_clear,
    output logic                  pwm_out,
    output logic                  channel_enable_status_bit,
    output logic                  period_event,
    output logic [15:0]           counter,
    output logic [15:0]           period
);
    chan_state_t state;
    chan_state_t next_state;
    logic        tick;
    logic        first;
    logic        next_first;
    logic [15:0] next_counter;
    logic [15:0] next_period;
    logic [15:0] pending;
    logic [15:0] next_pending;
    logic        pend_valid;
    logic        next_pend_valid;
    logic        next_event;
    logic        next_status;
    logic        next_pwm;
    logic        period_end;
    logic        running;

    // A zero-width ratio leaves the divider without a counter
    if (DIV_W < 1)
    begin : g_bad_div_w
        $error("DIV_W must be at least 1");
    end

    tick_divider #(.DIV_W(DIV_W)) u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .div_ratio (div_ratio),
        .tick      (tick)
    );

    assign running    = (state == ST_RUN) || (state == ST_DRAIN);
    assign period_end = running && tick && (counter >= period); // [RL9]

    always_comb
    begin
        next_state      = state;
        next_first      = first;
        next_counter    = counter;
        next_period     = period;
        next_pending    = pending;
        next_pend_valid = pend_valid;
        next_event      = period_event;
        next_status     = channel_enable_status_bit;
        next_pwm        = pwm_out;
        case (state)
            ST_IDLE:
            begin
                next_pwm = polarity;
                if (chan_enable)
                begin
                    next_state   = ST_RUN;
                    next_counter = CNT_START; // [RL2]
                    next_first   = 1'b1;
                    next_status  = 1'b1;
                    next_period  = (init_period == ZERO_PERIOD) ? period : init_period;
                    if (center_align_select)
                        next_event = 1'b1; // [RL3]
                end
            end
            ST_RUN, ST_DRAIN:
            begin
                if (state == ST_RUN && chan_disable)
                    next_state = ST_DRAIN; // [RL7]
                if (tick)
                begin
                    if (period_end)
                    begin
                        next_counter = CNT_RELOAD; // [RL1]
                        next_first   = 1'b0;
                        next_event   = 1'b1;
                        if (pend_valid)
                        begin
                            next_period     = pending;
                            next_pend_valid = 1'b0;
                        end
                        if (state == ST_DRAIN || chan_disable)
                        begin
                            next_state  = ST_IDLE;
                            next_status = 1'b0; // [RL7]
                        end
                    end
                    else
                        next_counter = counter + 16'h0001; // [RL9]
                    next_pwm = (counter < duty) ? ~polarity : polarity;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        // Zero would stall the counter; keep the old value.
        // Placed after the case so a write on a period end is queued, not lost
        if (update_write && channel_update_value != ZERO_PERIOD) // [RL5]
        begin
            next_pending    = channel_update_value;
            next_pend_valid = 1'b1;
        end
        // Set wins over a same-cycle clear
        if (event_clear && !(period_end || (state == ST_IDLE && chan_enable
                                            && center_align_select)))
            next_event = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state                     <= ST_IDLE;
            first                     <= 1'b0;
            counter                   <= CNT_START;
            period                    <= PERIOD_RESET;
            pending                   <= PERIOD_RESET;
            pend_valid                <= 1'b0;
            period_event              <= 1'b0;
            channel_enable_status_bit <= 1'b0;
            pwm_out                   <= 1'b0;
        end
        else if (ce)
        begin
            state                     <= next_state;
            first                     <= next_first;
            counter                   <= next_counter;
            period                    <= next_period;
            pending                   <= next_pending;
            pend_valid                <= next_pend_valid;
            period_event              <= next_event;
            channel_enable_status_bit <= next_status;
            pwm_out                   <= next_pwm;
        end
    end

    property p_reload_one;
        @(posedge clk_sys) disable iff (rst)
        (ce && period_end) |=> (counter == CNT_RELOAD);
    endproperty
    a_reload_one: assert property (p_reload_one) else $error("counter not reloaded to one"); // [RL1]

    property p_first_zero;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ST_IDLE && chan_enable) |=> (counter == CNT_START && first);
    endproperty
    a_first_zero: assert property (p_first_zero) else $error("first period not from zero"); // [RL2]

    property p_center_event;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ST_IDLE && chan_enable && center_align_select) |=> period_event;
    endproperty
    a_center_event: assert property (p_center_event) else $error("no event on center enable"); // [RL3]

    property p_zero_ignored;
        @(posedge clk_sys) disable iff (rst)
        (ce && update_write && channel_update_value == ZERO_PERIOD && !pend_valid)
        |=> !pend_valid;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored) else $error("zero period accepted"); // [RL5]

    property p_status_holds;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ST_RUN && chan_disable && !period_end)
        |=> channel_enable_status_bit && state == ST_DRAIN;
    endproperty
    a_status_holds: assert property (p_status_holds) else $error("status dropped early"); // [RL7]

    property p_status_falls;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ST_DRAIN && period_end) |=> !channel_enable_status_bit;
    endproperty
    a_status_falls: assert property (p_status_falls) else $error("status not cleared"); // [RL7]

    property p_count_step;
        @(posedge clk_sys) disable iff (rst)
        (ce && running && tick && !period_end) |=> (counter == $past(counter) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step"); // [RL9]

    property p_end_event;
        @(posedge clk_sys) disable iff (rst)
        (ce && period_end) |=> period_event;
    endproperty
    a_end_event: assert property (p_end_event) else $error("period end without event"); // [RL9]

    property p_period_nonzero;
        @(posedge clk_sys) disable iff (rst)
        running |-> (period != ZERO_PERIOD);
    endproperty
    a_period_nonzero: assert property (p_period_nonzero) else $error("zero period active"); // [RL5]

    c_center: cover property (@(posedge clk_sys) disable iff (rst)
        state == ST_IDLE && chan_enable && center_align_select);
    c_drain: cover property (@(posedge clk_sys) disable iff (rst)
        state == ST_DRAIN && period_end);
    c_second: cover property (@(posedge clk_sys) disable iff (rst)
        period_end && !first);
    c_zero_refused: cover property (@(posedge clk_sys) disable iff (rst)
        running && update_write && channel_update_value == ZERO_PERIOD);
endmodule : pwm_channel

// file: core/pwm_chan_pkg.sv
package pwm_chan_pkg;
    localparam int          CNT_W        = 16;
    localparam logic [15:0] CNT_START    = 16'h0000;
    localparam logic [15:0] CNT_RELOAD   = 16'h0001;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] DUTY_RESET   = 16'h0000;
    localparam logic [15:0] ZERO_PERIOD  = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_RUN      = 3'b010,
        ST_DRAIN    = 3'b100
    } chan_state_t;
endpackage : pwm_chan_pkg

// file: core/tick_divider.sv
module tick_divider
    import pwm_chan_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [DIV_W-1:0] div_ratio,
    output logic                  tick
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             next_tick;

    // Checked at elaboration, before any cycle runs
    if (DIV_W < 1)
    begin : g_bad_div_w
        $error("DIV_W must be at least 1");
    end

    // Ratio 0 means every clock
    always_comb
    begin
        next_tick  = 1'b0;
        next_count = count + {{(DIV_W-1){1'b0}}, 1'b1};
        if (count >= div_ratio)
        begin
            next_count = '0;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else if (ce)
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : tick_divider

// file: testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_chan_pkg::*;

    typedef struct {
        logic [15:0] per;
        logic        ctr;
        logic [7:0]  div;
        logic        ev;
        logic        pol;
    } row_t;

    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        ce      = 1'b1;
    logic        chan_enable = 1'b0;
    logic        chan_disable = 1'b0;
    logic        center_align_select = 1'b0;
    logic        polarity = 1'b0;
    logic [7:0]  div_ratio = 8'h00;
    logic [15:0] init_period = 16'h0003;
    logic [15:0] duty = 16'h0002;
    logic        update_write = 1'b0;
    logic [15:0] channel_update_value = 16'h0000;
    logic        event_clear = 1'b0;
    logic        pwm_out;
    logic        channel_enable_status_bit;
    logic        period_event;
    logic [15:0] counter;
    logic [15:0] period;
    int          err_total = 0;
    int          check_count = 0;
    row_t        rows [3] = '{'{16'h0002, 1'b1, 8'h00, 1'b1, 1'b0},
                              '{16'h0003, 1'b0, 8'h02, 1'b0, 1'b1},
                              '{16'h0007, 1'b1, 8'h01, 1'b1, 1'b0}};

    pwm_channel #(.DIV_W(8)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .chan_enable(chan_enable),
        .chan_disable(chan_disable), .center_align_select(center_align_select),
        .polarity(polarity), .div_ratio(div_ratio), .init_period(init_period),
        .duty(duty), .update_write(update_write),
        .channel_update_value(channel_update_value), .event_clear(event_clear),
        .pwm_out(pwm_out), .channel_enable_status_bit(channel_enable_status_bit),
        .period_event(period_event), .counter(counter), .period(period)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // Fresh reset before each start so earlier runs leave no pending state
    task automatic start(input logic [15:0] p, input logic c, input logic e);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        init_period = p;
        center_align_select = c;
        chan_enable = 1'b1;
        cyc(1);
        chan_enable = 1'b0;
        check("status", {15'h0, channel_enable_status_bit}, 16'h0001);
        check("event", {15'h0, period_event}, {15'h0, e});
    endtask : start

    // Divider phase at enable is free, so the first step's spacing is not checked
    task automatic follow(input logic [15:0] p, input logic c, input int n);
        logic [15:0] exp;
        logic [15:0] last;
        logic        ev;
        int          gap;
        int          steps;
        exp = 16'h0000;
        last = counter;
        ev = c;
        gap = 0;
        steps = 0;
        check("counter", counter, 16'h0000);
        repeat (n)
        begin
            cyc(1);
            gap++;
            if (counter !== last)
            begin
                ev = ev | (exp >= p);
                check("pwm", {15'h0, pwm_out}, {15'h0, (exp < duty) ^ polarity});
                exp = (exp >= p) ? 16'h0001 : exp + 16'h0001;
                check("counter", counter, exp);
                check("event", {15'h0, period_event}, {15'h0, ev});
                if (steps > 0)
                    check("gap", gap[15:0], {8'h00, div_ratio} + 16'h0001);
                steps++;
                gap = 0;
                last = counter;
            end
        end
        check("steps", steps[15:0], (p << 1) + 16'h0004);
    endtask : follow

    task automatic wait_count(input logic [15:0] v);
        int n;
        n = 0;
        while (counter !== v && n < 40)
        begin
            cyc(1);
            n++;
        end
        check("reach", counter, v);
    endtask : wait_count

    initial
    begin
        logic [15:0] held;
        cyc(12);
        rst = 1'b0;
        cyc(2);
        check("period", period, PERIOD_RESET);
        check("pwm", {15'h0, pwm_out}, 16'h0000);
        check("status", {15'h0, channel_enable_status_bit}, 16'h0000);
        check("event", {15'h0, period_event}, 16'h0000);
        check("counter", counter, CNT_START);
        foreach (rows[i])
        begin
            div_ratio = rows[i].div;
            polarity = rows[i].pol;
            start(rows[i].per, rows[i].ctr, rows[i].ev);
            follow(rows[i].per, rows[i].ctr, (2 * rows[i].per + 4) * (rows[i].div + 1));
        end
        div_ratio = 8'h00;
        polarity = 1'b0;
        start(16'h0003, 1'b0, 1'b0);
        wait_count(16'h0002);
        // Deliberately breaks the software side to show the write is refused
        update_write = 1'b1;
        channel_update_value = 16'h0000;
        cyc(1);
        update_write = 1'b0;
        cyc(6);
        check("period", period, 16'h0003);
        update_write = 1'b1;
        channel_update_value = 16'h0005;
        cyc(1);
        update_write = 1'b0;
        cyc(8);
        check("period", period, 16'h0005);
        ce = 1'b0;
        held = counter;
        cyc(4);
        check("frozen", counter, held);
        ce = 1'b1;
        start(16'h0007, 1'b1, 1'b1);
        event_clear = 1'b1;
        cyc(1);
        event_clear = 1'b0;
        check("cleared", {15'h0, period_event}, 16'h0000);
        wait_count(16'h0003);
        chan_disable = 1'b1;
        cyc(1);
        chan_disable = 1'b0;
        while (counter !== 16'h0007 && check_count < 200)
        begin
            check("status", {15'h0, channel_enable_status_bit}, 16'h0001);
            cyc(1);
        end
        check("counter", counter, 16'h0007);
        check("status", {15'h0, channel_enable_status_bit}, 16'h0001);
        cyc(3);
        check("status", {15'h0, channel_enable_status_bit}, 16'h0000);
        results();
    end

    // Whole run needs under two hundred cycles
    initial
    begin
        #100us;
        err_total++;
        results();
    end
endmodule : tb
